/* File: design/srs_pkg.sv */
package srs_pkg;
  // Width of every part of a status register
  localparam int SRS_REG_W = 16;
  // Width of the status byte and its enable mask
  localparam int SRS_STB_W = 8;
  // Most significant bit of a part, always zero
  localparam int SRS_MSB = 15;
  // Power indication position in the questionable register
  localparam int SRS_QUES_POWER_BIT = 9;

  // Targets selectable by a command
  localparam logic [1:0] SRS_TGT_QUES = 2'h0;
  localparam logic [1:0] SRS_TGT_OPER = 2'h1;
  localparam logic [1:0] SRS_TGT_STB = 2'h2;
  localparam logic [1:0] SRS_TGT_SRE = 2'h3;

  // Parts of a status register
  localparam logic [2:0] SRS_PART_COND = 3'h0;
  localparam logic [2:0] SRS_PART_PTR = 3'h1;
  localparam logic [2:0] SRS_PART_NTR = 3'h2;
  localparam logic [2:0] SRS_PART_EVENT = 3'h3;
  localparam logic [2:0] SRS_PART_ENABLE = 3'h4;

  // Index of each status register in the arrays
  localparam int SRS_IDX_QUES = 0;
  localparam int SRS_IDX_OPER = 1;
  localparam int SRS_NUM_REGS = 2;

  // Status byte bit positions
  localparam int SRS_STB_ERRQ = 2;
  localparam int SRS_STB_QUES = 3;
  localparam int SRS_STB_MAV = 4;
  localparam int SRS_STB_ESB = 5;
  localparam int SRS_STB_MSS = 6;
  localparam int SRS_STB_OPER = 7;

  // Reset values
  localparam logic [15:0] SRS_PART_RESET = 16'h0000;
  localparam logic [7:0] SRS_BYTE_RESET = 8'h00;
  // Mask that keeps the most significant bit of a part at zero
  localparam logic [15:0] SRS_PART_MASK = 16'h7fff;
  // Mask that removes the summary position from the enable mask
  localparam logic [7:0] SRS_SRE_MASK = 8'hbf;
  // Mask that forces the unused status byte positions to zero
  localparam logic [7:0] SRS_STB_USED = 8'hfc;

  // One controller command: read or write of one part
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] target;
    logic [2:0] part;
    logic [15:0] data;
  } srs_cmd_t;

  // Answer to a read or a serial poll
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } srs_rsp_t;
endpackage

/* File: design/srs_status_reporting.sv */
// Operation
// - Five sixteen-bit parts per status register
// - Same bit position across parts, independent bits
// - Bit fifteen of every part reads zero
// - Questionable bit nine carries power status
// - Condition mirrors hardware inputs and power status
// - Condition is read-only, unchanged by reads
// - Rising condition sets event if rising filter
// - Falling condition sets event if falling filter
// - Transition filters freely readable and writable
// - Event latches filtered transitions until read
// - Event read-only, cleared entirely by read
// - Sum bit is OR of event AND enable
// - Enable part freely readable and writable
// - Sum bit feeds higher register condition bit
// - Status byte bit six summarises enabled bits
// - Status byte answered to query and poll
// - Request mask per bit, bit six ignored
// - Enabled status bit rising raises service request
// - Request mask written and read back
// - Bit two reports error queue, entries request
// - Bit three is questionable sum bit
// - Bit four while output message waits
// - Bit five from enabled standard event bits
// - Bit seven is operation sum bit
`timescale 1ns/100ps
module srs_status_reporting
(
  input wire logic clk,
  input wire logic rst,
  // Hardware status for the questionable register, bit 9 and 15 unused
  input wire logic [15:0] quesHw,
  // Power-related status indication
  input wire logic powerStatus,
  // Hardware status for the operation register, bit 15 unused
  input wire logic [15:0] operHw,
  // Error queue holds at least one entry
  input wire logic errQueueNotEmpty,
  // One-cycle pulse for each new error queue entry
  input wire logic errEntry,
  // Readable message waits in the output buffer
  input wire logic msgAvailable,
  // Standard event status bits and their enable mask
  input wire logic [7:0] stdEventStatus,
  input wire logic [7:0] stdEventEnable,
  // Controller command
  input wire srs_pkg::srs_cmd_t cmd,
  // Serial poll request, one-cycle pulse
  input wire logic serialPoll,
  // Answer to reads and polls
  output srs_pkg::srs_rsp_t rsp,
  // Service request, one-cycle pulse
  output logic srq,
  // Present status byte
  output logic [7:0] statusByte
);
  import srs_pkg::*;

  // Condition, previous condition, filters, events and enables
  logic [15:0] cond [SRS_NUM_REGS];
  logic [15:0] prevCond [SRS_NUM_REGS];
  logic [15:0] risingFilter [SRS_NUM_REGS];
  logic [15:0] fallingFilter [SRS_NUM_REGS];
  logic [15:0] eventPart [SRS_NUM_REGS];
  logic [15:0] enablePart [SRS_NUM_REGS];
  // Service request enable mask
  logic [7:0] srEnable;
  // Status byte as seen one cycle earlier, for edge detection
  logic [7:0] prevStatusByte;
  // Sum bits of both registers
  logic [SRS_NUM_REGS-1:0] sumBit;
  // Filtered transitions of this cycle
  logic [15:0] newEvents [SRS_NUM_REGS];
  // Raw hardware sources per register
  logic [15:0] condSource [SRS_NUM_REGS];
  // Decoded command strobes
  logic isRead;
  logic isWrite;
  logic [15:0] readValue;

  // Filtered transitions of one register
  function automatic logic [15:0] filterEdges(input logic [15:0] now, input logic [15:0] prev,
                                             input logic [15:0] ptr, input logic [15:0] ntr);
    filterEdges = ((now & ~prev & ptr) | (~now & prev & ntr)) & SRS_PART_MASK;
  endfunction

  // Sum of enabled events of one register
  function automatic logic sumOf(input logic [15:0] ev, input logic [15:0] en);
    sumOf = |(ev & en);
  endfunction

  // Command strobes
  assign isRead = cmd.valid && !cmd.write;
  assign isWrite = cmd.valid && cmd.write;

  // Questionable source, power indication at its fixed position
  always_comb
  begin
    condSource[SRS_IDX_QUES] = quesHw & SRS_PART_MASK;
    condSource[SRS_IDX_QUES][SRS_QUES_POWER_BIT] = powerStatus;
    condSource[SRS_IDX_OPER] = operHw & SRS_PART_MASK;
  end

  // Per-register transitions and sum bits
  always_comb
  begin
    for (int r = 0; r < SRS_NUM_REGS; r++)
    begin
      newEvents[r] = filterEdges(cond[r], prevCond[r], risingFilter[r], fallingFilter[r]);
      sumBit[r] = sumOf(eventPart[r], enablePart[r]);
    end
  end

  // Condition parts follow their sources; no write path reaches them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int r = 0; r < SRS_NUM_REGS; r++)
      begin
        cond[r] <= SRS_PART_RESET;
        prevCond[r] <= SRS_PART_RESET;
      end
    end
    else
    begin
      for (int r = 0; r < SRS_NUM_REGS; r++)
      begin
        cond[r] <= condSource[r];
        prevCond[r] <= cond[r];
      end
    end
  end

  // Filter and enable parts written by the controller
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int r = 0; r < SRS_NUM_REGS; r++)
      begin
        risingFilter[r] <= SRS_PART_RESET;
        fallingFilter[r] <= SRS_PART_RESET;
        enablePart[r] <= SRS_PART_RESET;
      end
    end
    else if (isWrite && (cmd.target == SRS_TGT_QUES || cmd.target == SRS_TGT_OPER))
    begin
      // Target 0 or 1 doubles as array index
      if (cmd.part == SRS_PART_PTR)
      begin
        risingFilter[cmd.target[0]] <= cmd.data & SRS_PART_MASK;
      end
      else if (cmd.part == SRS_PART_NTR)
      begin
        fallingFilter[cmd.target[0]] <= cmd.data & SRS_PART_MASK;
      end
      else if (cmd.part == SRS_PART_ENABLE)
      begin
        enablePart[cmd.target[0]] <= cmd.data & SRS_PART_MASK;
      end
    end
  end

  // Event parts: latch filtered edges, cleared by their own read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int r = 0; r < SRS_NUM_REGS; r++)
      begin
        eventPart[r] <= SRS_PART_RESET;
      end
    end
    else
    begin
      for (int r = 0; r < SRS_NUM_REGS; r++)
      begin
        // A new edge in the clearing cycle still lands
        if (isRead && cmd.target == 2'(r) && cmd.part == SRS_PART_EVENT)
        begin
          eventPart[r] <= newEvents[r];
        end
        else
        begin
          eventPart[r] <= eventPart[r] | newEvents[r];
        end
      end
    end
  end

  // Service request enable mask, summary position ignored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srEnable <= SRS_BYTE_RESET;
    end
    else if (isWrite && cmd.target == SRS_TGT_SRE)
    begin
      srEnable <= cmd.data[7:0] & SRS_SRE_MASK;
    end
  end

  // Status byte assembled from the lower levels
  always_comb
  begin
    statusByte = SRS_BYTE_RESET;
    statusByte[SRS_STB_ERRQ] = errQueueNotEmpty;
    statusByte[SRS_STB_QUES] = sumBit[SRS_IDX_QUES];
    statusByte[SRS_STB_MAV] = msgAvailable;
    statusByte[SRS_STB_ESB] = |(stdEventStatus & stdEventEnable);
    statusByte[SRS_STB_OPER] = sumBit[SRS_IDX_OPER];
    statusByte[SRS_STB_MSS] = |(statusByte & srEnable & SRS_SRE_MASK & SRS_STB_USED);
  end

  // Service request on an enabled rising status bit or a new error entry while mask bit two is set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prevStatusByte <= SRS_BYTE_RESET;
      srq <= 1'b0;
    end
    else
    begin
      prevStatusByte <= statusByte;
      srq <= (|(statusByte & ~prevStatusByte & srEnable & SRS_SRE_MASK)) ||
             (errEntry && srEnable[SRS_STB_ERRQ]);
    end
  end

  // Read multiplexer
  always_comb
  begin
    readValue = SRS_PART_RESET;
    if (cmd.target == SRS_TGT_STB)
    begin
      readValue = {8'h00, statusByte};
    end
    else if (cmd.target == SRS_TGT_SRE)
    begin
      readValue = {8'h00, srEnable};
    end
    else if (cmd.part == SRS_PART_COND)
    begin
      readValue = cond[cmd.target[0]];
    end
    else if (cmd.part == SRS_PART_PTR)
    begin
      readValue = risingFilter[cmd.target[0]];
    end
    else if (cmd.part == SRS_PART_NTR)
    begin
      readValue = fallingFilter[cmd.target[0]];
    end
    else if (cmd.part == SRS_PART_EVENT)
    begin
      readValue = eventPart[cmd.target[0]];
    end
    else if (cmd.part == SRS_PART_ENABLE)
    begin
      readValue = enablePart[cmd.target[0]];
    end
  end

  // Answer register: serial poll wins over a command read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp <= '0;
    end
    else if (serialPoll)
    begin
      rsp.valid <= 1'b1;
      rsp.data <= {8'h00, statusByte};
    end
    else if (isRead)
    begin
      rsp.valid <= 1'b1;
      rsp.data <= readValue & SRS_PART_MASK;
    end
    else
    begin
      rsp.valid <= 1'b0;
    end
  end

  // Helper signals for the checks
  logic quesRiseHit, quesFallHit, quesEvRead;
  assign quesRiseHit = |(cond[SRS_IDX_QUES] & ~prevCond[SRS_IDX_QUES]
                         & risingFilter[SRS_IDX_QUES]);
  assign quesFallHit = |(~cond[SRS_IDX_QUES] & prevCond[SRS_IDX_QUES]
                         & fallingFilter[SRS_IDX_QUES]);
  assign quesEvRead = isRead && cmd.target == SRS_TGT_QUES && cmd.part == SRS_PART_EVENT;

  // Clearing read of the questionable event part
  sequence s_clear_read;
    quesEvRead && newEvents[SRS_IDX_QUES] == SRS_PART_RESET;
  endsequence

  // Answers never show bit 15
  property p_msb_zero;
    @(posedge clk) disable iff (rst) rsp.valid |-> !rsp.data[SRS_MSB];
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("answer bit 15 set");

  // Condition follows source one cycle later
  property p_cond_mirror;
    @(posedge clk) disable iff (rst)
      1'b1 |=> cond[SRS_IDX_QUES] == $past(condSource[SRS_IDX_QUES]);
  endproperty
  a_cond_mirror: assert property (p_cond_mirror) else $error("condition not mirrored");

  // Enabled rising edge reaches the event part
  property p_rise_event;
    @(posedge clk) disable iff (rst) quesRiseHit |=> eventPart[SRS_IDX_QUES] != SRS_PART_RESET;
  endproperty
  a_rise_event: assert property (p_rise_event) else $error("rising edge lost");

  // Enabled falling edge reaches the event part
  property p_fall_event;
    @(posedge clk) disable iff (rst) quesFallHit |=> eventPart[SRS_IDX_QUES] != SRS_PART_RESET;
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("falling edge lost");

  // Clearing read with no new edge empties the event part
  property p_read_clears;
    @(posedge clk) disable iff (rst) s_clear_read |=> eventPart[SRS_IDX_QUES] == SRS_PART_RESET;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("event not cleared");

  // Edge in the clearing cycle survives
  property p_set_wins;
    @(posedge clk) disable iff (rst)
      quesEvRead && quesRiseHit |=> eventPart[SRS_IDX_QUES] != SRS_PART_RESET;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  // Questionable sum bit appears in the status byte
  property p_ques_sum;
    @(posedge clk) disable iff (rst)
      statusByte[SRS_STB_QUES] == |(eventPart[SRS_IDX_QUES] & enablePart[SRS_IDX_QUES]);
  endproperty
  a_ques_sum: assert property (p_ques_sum) else $error("questionable sum wrong");

  // Enabled status bit rising gives a request next cycle
  property p_srq_raise;
    @(posedge clk) disable iff (rst)
      |(statusByte & ~$past(statusByte) & srEnable & SRS_SRE_MASK) |=> srq;
  endproperty
  a_srq_raise: assert property (p_srq_raise) else $error("service request missing");

  // Mask summary position never stored
  property p_sre_bit6;
    @(posedge clk) disable iff (rst)
      isWrite && cmd.target == SRS_TGT_SRE |=> !srEnable[SRS_STB_MSS];
  endproperty
  a_sre_bit6: assert property (p_sre_bit6) else $error("mask bit 6 stored");

  // Unused status byte positions stay zero
  property p_unused_zero;
    @(posedge clk) disable iff (rst) statusByte[1:0] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");
endmodule

/* File: testbench/srs_remote_ctrl.sv */
`timescale 1ns/100ps
module srs_remote_ctrl
(
  input wire logic clk,
  output srs_pkg::srs_cmd_t cmd,
  output logic serialPoll
);
  import srs_pkg::*;
  // Bus idle at start
  initial
  begin
    cmd = '0;
    serialPoll = 1'h0;
  end
  // One command for one cycle, then released with inverted lines
  task automatic send(input logic w, input logic [1:0] t, input logic [2:0] p,
    input logic [15:0] d);
    @(negedge clk);
    cmd <= {1'h1, w, t, p, d};
    @(negedge clk);
    cmd <= {1'h0, ~w, ~t, ~p, ~d};
  endtask
  // Serial poll pulse of one cycle
  task automatic poll();
    @(negedge clk);
    serialPoll <= 1'h1;
    @(negedge clk);
    serialPoll <= 1'h0;
  endtask
endmodule

/* File: testbench/srs_status_reporting_bench.sv */
`timescale 1ns/100ps
module srs_status_reporting_bench;
  import srs_pkg::*;
  // Design pins
  logic clk, rst, powerStatus, errQueueNotEmpty, errEntry, msgAvailable, serialPoll, srq;
  logic [15:0] quesHw, operHw;
  logic [7:0] stdEventStatus, stdEventEnable, statusByte;
  srs_cmd_t cmd;
  srs_rsp_t rsp;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 18;
  int t;
  // Reference model state, index 0 questionable, 1 operation
  logic [15:0] cm [2], pm [2], ptrM [2], ntrM [2], em [2], enM [2], hw [2];
  logic [15:0] expD, edges;
  logic [7:0] maskM, byteM, byteQ, low;
  logic srqM, expV;

  srs_status_reporting u_srs_status_reporting (.clk(clk), .rst(rst), .quesHw(quesHw),
    .powerStatus(powerStatus), .operHw(operHw), .errQueueNotEmpty(errQueueNotEmpty),
    .errEntry(errEntry), .msgAvailable(msgAvailable), .stdEventStatus(stdEventStatus),
    .stdEventEnable(stdEventEnable), .cmd(cmd), .serialPoll(serialPoll), .rsp(rsp),
    .srq(srq), .statusByte(statusByte));
  srs_remote_ctrl u_srs_remote_ctrl (.clk(clk), .cmd(cmd), .serialPoll(serialPoll));

  // Free running clock
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare one result
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (e !== s)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  // Value a read of target and part returns
  function automatic logic [15:0] rdval(input logic [1:0] tg, input logic [2:0] p);
    if (tg == SRS_TGT_STB)
      return {8'h00, byteM};
    if (tg == SRS_TGT_SRE)
      return {8'h00, maskM};
    case (p)
      SRS_PART_COND: return cm[tg[0]];
      SRS_PART_PTR: return ptrM[tg[0]];
      SRS_PART_NTR: return ntrM[tg[0]];
      SRS_PART_EVENT: return em[tg[0]];
      SRS_PART_ENABLE: return enM[tg[0]];
      default: return 16'h0000;
    endcase
  endfunction

  // Condition inputs and status byte of the model
  always_comb
  begin
    hw[0] = {1'h0, quesHw[14:10], powerStatus, quesHw[8:0]};
    hw[1] = {1'h0, operHw[14:0]};
    low = {|(em[1] & enM[1]), 1'h0, |(stdEventStatus & stdEventEnable), msgAvailable,
      |(em[0] & enM[0]), errQueueNotEmpty, 2'h0};
    byteM = low | {1'h0, |(low & maskM), 6'h00};
  end

  // Clocked model of parts, request and answers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int r = 0; r < 2; r++)
      begin
        cm[r] <= 16'h0000;
        pm[r] <= 16'h0000;
        ptrM[r] <= 16'h0000;
        ntrM[r] <= 16'h0000;
        em[r] <= 16'h0000;
        enM[r] <= 16'h0000;
      end
      maskM <= 8'h00;
      byteQ <= 8'h00;
      srqM <= 1'h0;
      expV <= 1'h0;
      expD <= 16'h0000;
    end
    else
    begin
      for (int r = 0; r < 2; r++)
      begin
        edges = (cm[r] & ~pm[r] & ptrM[r]) | (~cm[r] & pm[r] & ntrM[r]);
        em[r] <= ((cmd.valid && !cmd.write && cmd.target == r && cmd.part == SRS_PART_EVENT)
          ? 16'h0000 : em[r]) | edges;
        pm[r] <= cm[r];
        cm[r] <= hw[r];
        if (cmd.valid && cmd.write && cmd.target == r)
        begin
          case (cmd.part)
            SRS_PART_PTR: ptrM[r] <= cmd.data & SRS_PART_MASK;
            SRS_PART_NTR: ntrM[r] <= cmd.data & SRS_PART_MASK;
            SRS_PART_ENABLE: enM[r] <= cmd.data & SRS_PART_MASK;
            default: ;
          endcase
        end
      end
      if (cmd.valid && cmd.write && cmd.target == SRS_TGT_SRE)
        maskM <= cmd.data[7:0] & SRS_SRE_MASK;
      srqM <= |(byteM & ~byteQ & maskM) | (errEntry & maskM[SRS_STB_ERRQ]);
      byteQ <= byteM;
      expV <= serialPoll | (cmd.valid & !cmd.write);
      expD <= serialPoll ? {8'h00, byteM} : rdval(cmd.target, cmd.part);
    end
  end

  // Status byte, request and answer valid compared once a cycle, answer data only when valid
  always @(negedge clk)
  begin
    if (rst === 1'h0)
    begin
      cmp("statusByte", {8'h00, byteM}, {8'h00, statusByte});
      cmp("srq", {15'h0000, srqM}, {15'h0000, srq});
      cmp("rspValid", {15'h0000, expV}, {15'h0000, rsp.valid});
      if (expV === 1'h1)
        cmp("rspData", expD, rsp.data);
    end
  end

  // Main sequence
  initial
  begin
    {rst, powerStatus, errQueueNotEmpty, errEntry, msgAvailable} = 5'h10;
    {quesHw, operHw, stdEventStatus, stdEventEnable} = 48'h0;
    repeat (10) @(negedge clk);
    rst <= 1'h0;
    // Reset value, write attempt and read back of every part
    for (int i = 0; i < 32; i++)
    begin
      u_srs_remote_ctrl.send(1'h0, i[4:3], i[2:0], 16'h0000);
      u_srs_remote_ctrl.send(1'h1, i[4:3], i[2:0], 16'hffff);
      u_srs_remote_ctrl.send(1'h0, i[4:3], i[2:0], 16'h0000);
    end
    // Edges that meet a clearing read of the event part
    for (int k = 0; k < 8; k++)
    begin
      quesHw <= 16'($random(seed));
      u_srs_remote_ctrl.send(1'h0, SRS_TGT_QUES, SRS_PART_EVENT, 16'h0000);
    end
    // Random status traffic with commands, polls and a reset in mid-run
    for (int n = 0; n < 3000; n++)
    begin
      @(negedge clk);
      t = $random(seed);
      rst <= (n >= 1500 && n < 1503);
      if (t[1:0] == 2'h0)
        quesHw <= 16'($random(seed));
      if (t[3:2] == 2'h0)
        operHw <= 16'($random(seed));
      if (t[7:5] == 3'h0)
        powerStatus <= ~powerStatus;
      errEntry <= &t[10:8];
      // A new error entry leaves the queue not empty
      if (&t[10:8])
        errQueueNotEmpty <= 1'h1;
      else if (t[13:11] == 3'h0)
        errQueueNotEmpty <= t[14];
      if (t[17:15] == 3'h0)
        msgAvailable <= t[18];
      if (t[21:19] == 3'h0)
        {stdEventStatus, stdEventEnable} <= 16'($random(seed));
      case (t[24:22])
        3'h0: u_srs_remote_ctrl.send(1'h1, t[26:25], t[29:27], 16'($random(seed)));
        3'h1: u_srs_remote_ctrl.send(1'h0, t[26:25], t[29:27], 16'h0000);
        3'h2: u_srs_remote_ctrl.poll();
        default: ;
      endcase
    end
    wrap_up();
  end
endmodule
